/* design/lpmc_top.sv */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "lpmc_map.svh"
module lpmc_top
  import lpmc_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic [`LPMC_ADDR_W-1:0]     addr_i,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [31:0]                 rdata_o,
  input  wire logic                        sleep_req_i,
  input  wire logic                        lp_run_req_i,
  input  wire logic                        radio_need_i,
  input  wire logic                        code_in_sram_i,
  input  wire logic                        internal_rst_i,
  input  wire logic [`LPMC_NUM_REQ-1:0]    fast_osc_req_i,
  input  wire lpmc_wake_t                  wake_i,
  input  wire lpmc_uart_t                  sync_async_serial_port_i,
  input  wire lpmc_uart_t                  low_power_serial_port_i,
  input  wire logic                        twi_addr_match_i,
  output lpmc_pwr_t                        pwr_o,
  output logic                             internal_fast_oscillator_o,
  output logic [`LPMC_NUM_REQ-1:0]         fast_osc_gate_o,
  output logic [`LPMC_NUM_IO-1:0]          io_analog_o,
  output logic [`LPMC_NUM_IO-1:0]          io_pull_up_o,
  output logic [`LPMC_NUM_IO-1:0]          io_pull_dn_o,
  output logic                             rst_pin_pull_up_o,
  output logic                             sys_restart_o,
  output lpmc_state_t                      mode_o,
  output logic                             irq_o
);

  // asynchronous wake inputs pass two flops first
  localparam int SW = $bits(lpmc_wake_t) + 7 + `LPMC_NUM_REQ + 2;
  logic [SW-1:0] sync1_q, sync2_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {wake_i, sync_async_serial_port_i, low_power_serial_port_i,
                  twi_addr_match_i, fast_osc_req_i, radio_need_i,
                  internal_rst_i};
      sync2_q <= sync1_q;
    end
  end
  lpmc_wake_t                wk;
  lpmc_uart_t                us, lp;
  logic                      twi_s, radio_s, int_rst_s;
  logic [`LPMC_NUM_REQ-1:0]  req_s;
  assign {wk, us, lp, twi_s, req_s, radio_s, int_rst_s} = sync2_q;

  // register file
  logic [7:0]                ctrl_q;
  logic [`LPMC_NUM_IO-1:0]   pu_q, pd_q;
  logic [`LPMC_IRQ_W-1:0]    ist_q, ien_q;
  lpmc_state_t               st_q, st_d;
  lpmc_tgt_t                 tgt;
  wire wr_ctrl = wr_i && addr_i == `LPMC_OFF_CTRL;
  wire wr_pu   = wr_i && addr_i == `LPMC_OFF_PULL_UP;
  wire wr_pd   = wr_i && addr_i == `LPMC_OFF_PULL_DN;
  wire wr_ien  = wr_i && addr_i == `LPMC_OFF_IRQ_EN;
  wire wr_iclr = wr_i && addr_i == `LPMC_OFF_IRQ_CLR;
  assign tgt = lpmc_tgt_t'(ctrl_q[`LPMC_CTRL_MODE_LSB +: 3]);
  wire retain   = ctrl_q[`LPMC_CTRL_RETAIN];
  wire use_lpr  = ctrl_q[`LPMC_CTRL_LPR];
  wire in_stop  = st_q == LPMC_STOP0 || st_q == LPMC_STOP1;
  wire in_sleep = st_q == LPMC_SLEEP || st_q == LPMC_LP_SLEEP;
  wire in_lp    = st_q == LPMC_LP_RUN || st_q == LPMC_LP_SLEEP;
  // outside stop, standby and shutdown, flash may only power down with radio idle and code in sram
  wire flash_pd = ctrl_q[`LPMC_CTRL_FLASH_PD] && !radio_s &&
                  code_in_sram_i;

  // wake events seen in stop
  wire uart_wake = in_stop && (|us || |lp);
  wire twi_wake  = in_stop && twi_s;
  wire pin_wake  = wk.wake_pin_a || wk.wake_pin_b;
  // radio need only starts the external fast oscillator, the core stays stopped
  wire stop_wake = wk.irq_any || wk.io_any || wk.reset_pin || wk.rtc ||
                   wk.stop_src || pin_wake || uart_wake || twi_wake;
  wire sb_wake   = pin_wake || wk.rtc || wk.reset_pin || wk.stop_src;
  wire sd_wake   = pin_wake || wk.rtc;
  logic [`LPMC_IRQ_W-1:0] ev;
  assign ev = {twi_wake, uart_wake,
               (st_q != LPMC_RUN && st_q != LPMC_LP_RUN && st_d != st_q)};

  // mode sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      LPMC_RUN, LPMC_LP_RUN: begin
        if (sleep_req_i) begin
          unique case (tgt)
            LPMC_TGT_SLEEP:
              st_d = (st_q == LPMC_LP_RUN) ? LPMC_LP_SLEEP : LPMC_SLEEP;
            LPMC_TGT_STOP0:   st_d = LPMC_STOP0;
            LPMC_TGT_STOP1:   st_d = LPMC_STOP1;
            LPMC_TGT_STANDBY: st_d = LPMC_STANDBY;
            LPMC_TGT_SHUTDOWN: st_d = LPMC_SHUTDOWN;
            default:          st_d = st_q;
          endcase
        end else if (st_q == LPMC_RUN && lp_run_req_i && !radio_s) begin
          st_d = LPMC_LP_RUN;
        end else if (st_q == LPMC_LP_RUN && !lp_run_req_i) begin
          st_d = LPMC_RUN;
        end
      end
      LPMC_SLEEP:    if (wk.irq_any) st_d = LPMC_RUN;
      LPMC_LP_SLEEP: if (wk.irq_any) st_d = LPMC_LP_RUN;
      LPMC_STOP0, LPMC_STOP1: if (stop_wake) st_d = LPMC_RUN;
      LPMC_STANDBY:  if (sb_wake) st_d = LPMC_RUN;
      LPMC_SHUTDOWN: if (sd_wake) st_d = LPMC_RUN;
    endcase
  end
  wire restart = (st_q == LPMC_STANDBY || st_q == LPMC_SHUTDOWN) &&
                 st_d == LPMC_RUN;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= LPMC_RUN;
      ctrl_q <= `LPMC_CTRL_RST;
      pu_q   <= '0;
      pd_q   <= '0;
      ien_q  <= '0;
      ist_q  <= '0;
    end else begin
      st_q  <= st_d;
      ist_q <= (ist_q & ~({`LPMC_IRQ_W{wr_iclr}} & wdata_i[`LPMC_IRQ_W-1:0]))
               | ev;
      if (wr_ien) ien_q <= wdata_i[`LPMC_IRQ_W-1:0];
      if (restart) begin
        ctrl_q <= `LPMC_CTRL_RST;
        pu_q   <= (st_q == LPMC_SHUTDOWN) ? '0 : pu_q;
        pd_q   <= (st_q == LPMC_SHUTDOWN) ? '0 : pd_q;
      end else begin
        if (wr_ctrl) ctrl_q <= wdata_i[7:0];
        if (wr_pu) pu_q <= wdata_i[`LPMC_NUM_IO-1:0];
        if (wr_pd) pd_q <= wdata_i[`LPMC_NUM_IO-1:0];
      end
    end
  end

  // read mux, data in the cycle after the strobe
  logic [31:0] rd_d;
  assign rd_d =
    (addr_i == `LPMC_OFF_CTRL)     ? {24'h0, ctrl_q} :
    (addr_i == `LPMC_OFF_PULL_UP)  ? {16'h0, pu_q} :
    (addr_i == `LPMC_OFF_PULL_DN)  ? {16'h0, pd_q} :
    (addr_i == `LPMC_OFF_STATUS)   ? {28'h0, st_q} :
    (addr_i == `LPMC_OFF_IRQ_STAT) ? {29'h0, ist_q} :
    (addr_i == `LPMC_OFF_IRQ_EN)   ? {29'h0, ien_q} : 32'h0;

  // power plan per mode
  lpmc_pwr_t pw;
  wire sleep_like = in_sleep;
  always_comb begin
    pw = '0;
    pw.slow_osc_en     = 1'b1;
    pw.ext_fast_osc_en = radio_s && st_q != LPMC_STANDBY &&
                         st_q != LPMC_SHUTDOWN;
    pw.cpu_clk_en  = st_q == LPMC_RUN || st_q == LPMC_LP_RUN;
    pw.flash_on    = !in_stop && st_q != LPMC_STANDBY &&
                     st_q != LPMC_SHUTDOWN && !flash_pd;
    pw.sram_pwr_on = (st_q == LPMC_STANDBY) ? retain
                     : st_q != LPMC_SHUTDOWN;
    pw.sram1_clk_en = pw.sram_pwr_on && !(sleep_like &&
                      ctrl_q[`LPMC_CTRL_SRAM1_G]);
    pw.sram2_clk_en = pw.sram_pwr_on && !(sleep_like &&
                      ctrl_q[`LPMC_CTRL_SRAM2_G]);
    pw.radio_en    = !in_lp && st_q != LPMC_SHUTDOWN;
    pw.rng_en      = !in_lp && !in_stop && st_q != LPMC_STANDBY &&
                     st_q != LPMC_SHUTDOWN;
    pw.periph_run  = !in_stop && st_q != LPMC_STANDBY &&
                     st_q != LPMC_SHUTDOWN;
    pw.wake_per_en = st_q != LPMC_STANDBY && st_q != LPMC_SHUTDOWN;
    pw.low_power_regulator = in_lp || st_q == LPMC_STOP1 ||
                             (st_q == LPMC_STANDBY && retain);
    pw.main_regulator = !in_lp && st_q != LPMC_STOP1 &&
                        st_q != LPMC_STANDBY && st_q != LPMC_SHUTDOWN;
    if (st_q == LPMC_SHUTDOWN) pw.slow_osc_en = 1'b1;
    if (use_lpr && st_q == LPMC_STOP0) pw.low_power_regulator = 1'b0;
  end

  // fast oscillator follows requesters in stop, always on when running
  wire ifo_on = in_stop ? |req_s : !(st_q == LPMC_STANDBY ||
                                     st_q == LPMC_SHUTDOWN);
  logic [`LPMC_NUM_REQ-1:0] gate_d;
  genvar g;
  generate
    for (g = 0; g < `LPMC_NUM_REQ; g++) begin : g_req
      assign gate_d[g] = in_stop ? req_s[g] : ifo_on;
    end
  endgenerate

  wire standby_io = st_q == LPMC_STANDBY || st_q == LPMC_SHUTDOWN;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o     <= 32'h0;
      pwr_o       <= '0;
      internal_fast_oscillator_o <= 1'b0;
      fast_osc_gate_o <= '0;
      io_analog_o <= '1;
      io_pull_up_o <= '0;
      io_pull_dn_o <= '0;
      rst_pin_pull_up_o <= 1'b1;
      sys_restart_o <= 1'b0;
      mode_o      <= LPMC_RUN;
      irq_o       <= 1'b0;
    end else begin
      rdata_o     <= rd_i ? rd_d : 32'h0;
      pwr_o       <= pw;
      internal_fast_oscillator_o <= ifo_on;
      fast_osc_gate_o <= gate_d;
      io_analog_o <= '1;
      io_pull_up_o <= standby_io ? pu_q : '0;
      io_pull_dn_o <= standby_io ? pd_q : '0;
      rst_pin_pull_up_o <= !int_rst_s;
      sys_restart_o <= restart;
      mode_o      <= st_q;
      irq_o       <= |(ist_q & ien_q);
    end
  end

  // assertions
  property p_lp_radio_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      in_lp |=> !pwr_o.radio_en && !pwr_o.rng_en;
  endproperty
  a_lp_radio_off: assert property (p_lp_radio_off)
    else $error("radio or rng on in low-power mode");

  sequence s_sleep_wake;
    st_q == LPMC_SLEEP ##0 wk.irq_any;
  endsequence
  property p_sleep_wake;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_sleep_wake |=> st_q == LPMC_RUN ##1 pwr_o.cpu_clk_en;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep did not return to run");

  property p_stop_flash;
    @(posedge clk_i) disable iff (!rst_n_i)
      in_stop |=> !pwr_o.flash_on && pwr_o.sram_pwr_on && !pwr_o.periph_run;
  endproperty
  a_stop_flash: assert property (p_stop_flash)
    else $error("stop power plan wrong");

  property p_ifo_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      (in_stop && req_s == '0) |=> !internal_fast_oscillator_o;
  endproperty
  a_ifo_off: assert property (p_ifo_off)
    else $error("fast oscillator left on without requester");

  property p_radio_osc;
    @(posedge clk_i) disable iff (!rst_n_i)
      (radio_s && in_stop) |=> pwr_o.ext_fast_osc_en;
  endproperty
  a_radio_osc: assert property (p_radio_osc)
    else $error("external oscillator off with radio need");

  property p_uart_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
      (uart_wake && ien_q[`LPMC_IRQ_SERIAL]) |=> ##1 irq_o;
  endproperty
  a_uart_irq: assert property (p_uart_irq)
    else $error("serial wake interrupt missing");

  property p_sd_wake;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_q == LPMC_SHUTDOWN && !pin_wake && !wk.rtc) |=>
        st_q == LPMC_SHUTDOWN;
  endproperty
  a_sd_wake: assert property (p_sd_wake)
    else $error("shutdown left without pin or rtc");

  property p_retain;
    @(posedge clk_i) disable iff (!rst_n_i)
      st_q == LPMC_STANDBY |=> pwr_o.sram_pwr_on == $past(retain);
  endproperty
  a_retain: assert property (p_retain)
    else $error("sram retention mismatch");

  property p_pull_drop;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_q == LPMC_SHUTDOWN && restart) |=> pu_q == '0 && pd_q == '0;
  endproperty
  a_pull_drop: assert property (p_pull_drop)
    else $error("pull configuration kept after shutdown");

  property p_twi_stat;
    @(posedge clk_i) disable iff (!rst_n_i)
      twi_wake |=> ist_q[`LPMC_IRQ_TWI];
  endproperty
  a_twi_stat: assert property (p_twi_stat)
    else $error("two-wire wake not recorded");

  property p_sb_io;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_q == LPMC_STANDBY && wk.io_any && !sb_wake)
        |=> st_q == LPMC_STANDBY;
  endproperty
  a_sb_io: assert property (p_sb_io)
    else $error("general i/o woke standby");

  property p_sb_pulls;
    @(posedge clk_i) disable iff (!rst_n_i)
      st_q == LPMC_STANDBY |=>
        io_pull_up_o == $past(pu_q) && io_pull_dn_o == $past(pd_q);
  endproperty
  a_sb_pulls: assert property (p_sb_pulls)
    else $error("standby pull pattern not applied");

  property p_rst_pin;
    @(posedge clk_i) disable iff (!rst_n_i)
      int_rst_s |=> !rst_pin_pull_up_o;
  endproperty
  a_rst_pin: assert property (p_rst_pin)
    else $error("reset pin pull-up kept for internal reset");

  property p_sram1_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
      (in_sleep && ctrl_q[`LPMC_CTRL_SRAM1_G]) |=> !pwr_o.sram1_clk_en;
  endproperty
  a_sram1_gate: assert property (p_sram1_gate)
    else $error("sram1 clock not gated in sleep");

  sequence s_deep_exit;
    restart;
  endsequence
  property p_deep_exit;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_deep_exit |=> sys_restart_o && ctrl_q == `LPMC_CTRL_RST;
  endproperty
  a_deep_exit: assert property (p_deep_exit)
    else $error("deep wake did not restart");

  sequence s_stop_exit;
    in_stop && st_d == LPMC_RUN;
  endsequence
  property p_stop_exit;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_stop_exit |=> st_q == LPMC_RUN && !sys_restart_o;
  endproperty
  a_stop_exit: assert property (p_stop_exit)
    else $error("stop wake did not resume");

  property p_flash_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_q == LPMC_RUN && (radio_s || !code_in_sram_i))
        |=> pwr_o.flash_on;
  endproperty
  a_flash_keep: assert property (p_flash_keep)
    else $error("flash powered down while needed");

  property p_entry;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_q == LPMC_RUN && !sleep_req_i)
        |=> st_q == LPMC_RUN || st_q == LPMC_LP_RUN;
  endproperty
  a_entry: assert property (p_entry)
    else $error("low-power entry without request");

  property p_sd_plan;
    @(posedge clk_i) disable iff (!rst_n_i)
      st_q == LPMC_SHUTDOWN |=> !pwr_o.main_regulator &&
        !pwr_o.low_power_regulator && !pwr_o.flash_on && !pwr_o.wake_per_en;
  endproperty
  a_sd_plan: assert property (p_sd_plan)
    else $error("shutdown power plan wrong");
endmodule

/* inc/lpmc_map.svh */
`ifndef LPMC_MAP_SVH
`define LPMC_MAP_SVH
// register word offsets (byte addresses)
`define LPMC_ADDR_W        8
`define LPMC_OFF_CTRL      8'h00
`define LPMC_OFF_PULL_UP   8'h04
`define LPMC_OFF_PULL_DN   8'h08
`define LPMC_OFF_STATUS    8'h0c
`define LPMC_OFF_IRQ_STAT  8'h10
`define LPMC_OFF_IRQ_EN    8'h14
`define LPMC_OFF_IRQ_CLR   8'h18
// control field positions
`define LPMC_CTRL_MODE_LSB 0
`define LPMC_CTRL_LPR      3
`define LPMC_CTRL_RETAIN   4
`define LPMC_CTRL_FLASH_PD 5
`define LPMC_CTRL_SRAM1_G  6
`define LPMC_CTRL_SRAM2_G  7
`define LPMC_CTRL_RST      8'h00
// irq bit positions
`define LPMC_IRQ_WAKE      0
`define LPMC_IRQ_SERIAL    1
`define LPMC_IRQ_TWI       2
`define LPMC_IRQ_W         3
`define LPMC_NUM_IO        16
`define LPMC_NUM_REQ       4
`endif

/* inc/lpmc_pkg.sv */
package lpmc_pkg;
  // low-power target selected in control before the sleep request
  typedef enum logic [2:0] {
    LPMC_TGT_SLEEP    = 3'h0,
    LPMC_TGT_STOP0    = 3'h1,
    LPMC_TGT_STOP1    = 3'h2,
    LPMC_TGT_STANDBY  = 3'h3,
    LPMC_TGT_SHUTDOWN = 3'h4
  } lpmc_tgt_t;

  typedef enum logic [3:0] {
    LPMC_RUN, LPMC_LP_RUN, LPMC_SLEEP, LPMC_LP_SLEEP,
    LPMC_STOP0, LPMC_STOP1, LPMC_STANDBY, LPMC_SHUTDOWN
  } lpmc_state_t;

  // wake events from the always-on sources
  typedef struct packed {
    logic irq_any;      // any interrupt or event
    logic io_any;       // any general i/o edge
    logic wake_pin_a;
    logic wake_pin_b;
    logic rtc;
    logic reset_pin;
    logic stop_src;     // other stop-capable sources
  } lpmc_wake_t;

  // serial wake sources
  typedef struct packed {
    logic start_det;
    logic addr_match;
    logic frame_done;
  } lpmc_uart_t;

  // power and clock enables driven to the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic flash_on;
    logic sram_pwr_on;
    logic sram1_clk_en;
    logic sram2_clk_en;
    logic radio_en;
    logic rng_en;
    logic periph_run;   // non wake-capable peripherals clocked
    logic wake_per_en;  // wake-capable peripherals clocked
    logic slow_osc_en;
    logic ext_fast_osc_en;
    logic low_power_regulator;
    logic main_regulator;
  } lpmc_pwr_t;
endpackage

/* bench/lpmc_core_model.sv */
`timescale 1ns/1ns
module lpmc_core_model
  import lpmc_pkg::*;
(
  input  wire logic  clk_i,
  output logic       sleep_req_o,
  output logic       lp_run_req_o,
  output logic       radio_need_o,
  output logic       code_in_sram_o,
  output logic       internal_rst_o,
  output logic [3:0] fast_osc_req_o,
  output lpmc_wake_t wake_o,
  output lpmc_uart_t usart_o,
  output lpmc_uart_t lpuart_o,
  output logic       twi_match_o
);
  initial begin
    sleep_req_o = 1'b0;
    lp_run_req_o = 1'b0;
    radio_need_o = 1'b0;
    code_in_sram_o = 1'b0;
    internal_rst_o = 1'b0;
    fast_osc_req_o = 4'h0;
    wake_o = '0;
    usart_o = '0;
    lpuart_o = '0;
    twi_match_o = 1'b0;
  end

  // target mode is written to control before this is called
  task automatic request_sleep();
    @(posedge clk_i);
    sleep_req_o <= 1'b1;
    @(posedge clk_i);
    sleep_req_o <= 1'b0;
  endtask

  // level inputs, changed just after an edge
  task automatic set_level(input int unsigned k, input logic [3:0] v);
    @(posedge clk_i);
    case (k)
      0: lp_run_req_o <= v[0];
      1: radio_need_o <= v[0];
      2: code_in_sram_o <= v[0];
      3: internal_rst_o <= v[0];
      default: fast_osc_req_o <= v;
    endcase
  endtask

  // held three edges so the two-flop synchroniser cannot miss it
  task automatic fire(input int unsigned k);
    @(posedge clk_i);
    case (k)
      0: wake_o.irq_any <= 1'b1;
      1: wake_o.io_any <= 1'b1;
      2: wake_o.wake_pin_a <= 1'b1;
      3: wake_o.wake_pin_b <= 1'b1;
      4: wake_o.rtc <= 1'b1;
      5: usart_o.start_det <= 1'b1;
      6: lpuart_o.frame_done <= 1'b1;
      7: usart_o.addr_match <= 1'b1;
      8: lpuart_o.start_det <= 1'b1;
      9: wake_o.reset_pin <= 1'b1;
      10: wake_o.stop_src <= 1'b1;
      default: twi_match_o <= 1'b1;
    endcase
    repeat (3) @(posedge clk_i);
    wake_o <= '0;
    usart_o <= '0;
    lpuart_o <= '0;
    twi_match_o <= 1'b0;
  endtask
endmodule

/* bench/tb_low_power_mode_controller.sv */
`timescale 1ns/1ns
`include "lpmc_map.svh"
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_low_power_mode_controller
  import lpmc_pkg::*;
;
  logic        clk, rst_n, wr_s, rd_s, ifo, rpu, rs, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  gate;
  logic [15:0] ana, pu, pd;
  lpmc_pwr_t   pwr;
  lpmc_state_t mode;
  logic        sreq, lpreq, radio, csram, irst, twi;
  logic [3:0]  freq;
  lpmc_wake_t  wk;
  lpmc_uart_t  us, lu;
  int          errors, n_compared, n_rst;

  lpmc_core_model core_u (.clk_i(clk), .sleep_req_o(sreq),
    .lp_run_req_o(lpreq), .radio_need_o(radio), .code_in_sram_o(csram),
    .internal_rst_o(irst), .fast_osc_req_o(freq), .wake_o(wk),
    .usart_o(us), .lpuart_o(lu), .twi_match_o(twi));

  lpmc_top dut_u (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
    .sleep_req_i(sreq), .lp_run_req_i(lpreq), .radio_need_i(radio),
    .code_in_sram_i(csram), .internal_rst_i(irst), .fast_osc_req_i(freq),
    .wake_i(wk), .sync_async_serial_port_i(us),
    .low_power_serial_port_i(lu), .twi_addr_match_i(twi), .pwr_o(pwr),
    .internal_fast_oscillator_o(ifo), .fast_osc_gate_o(gate),
    .io_analog_o(ana), .io_pull_up_o(pu), .io_pull_dn_o(pd),
    .rst_pin_pull_up_o(rpu), .sys_restart_o(rs), .mode_o(mode),
    .irq_o(irq));

  always #5 clk = ~clk;
  always @(posedge clk) if (rs === 1'b1) n_rst++;

  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    `CHK(rdata & m, e)
  endtask

  // bounded wait, then the mode itself is compared
  task automatic go(input lpmc_state_t m);
    int i;
    for (i = 0; i < 12 && mode !== m; i++) @(posedge clk);
    @(negedge clk);
    `CHK(mode, m)
  endtask

  task automatic enter(input logic [31:0] ctl, input lpmc_state_t m);
    wr(`LPMC_OFF_CTRL, ctl);
    core_u.request_sleep();
    go(m);
    cyc(2);
  endtask

  task automatic t_reset();
    `CHK(ana, 16'hffff)
    core_u.set_level(3, 4'h1);
    cyc(4);
    `CHK(rpu, 1'b0)
    core_u.set_level(3, 4'h0);
    cyc(4);
    `CHK(rpu, 1'b1)
    rd(8'h40, 32'hffffffff, 32'h0);
    rd(`LPMC_OFF_IRQ_CLR, 32'hffffffff, 32'h0);
  endtask

  task automatic t_sleep();
    int i;
    for (i = 0; i < 2; i++) begin
      enter(32'h40 << i, LPMC_SLEEP);
      `CHK(pwr.cpu_clk_en, 1'b0)
      `CHK({pwr.sram1_clk_en, pwr.sram2_clk_en}, 2'b01 << i)
      core_u.fire(0);
      go(LPMC_RUN);
    end
  endtask

  task automatic t_low_power_run();
    core_u.set_level(0, 4'h1);
    go(LPMC_LP_RUN);
    cyc(2);
    `CHK({pwr.radio_en, pwr.rng_en}, 2'b00)
    enter(32'h0, LPMC_LP_SLEEP);
    `CHK({pwr.cpu_clk_en, pwr.radio_en, pwr.rng_en}, 3'b000)
    core_u.fire(0);
    go(LPMC_LP_RUN);
    core_u.set_level(0, 4'h0);
    go(LPMC_RUN);
  endtask

  task automatic t_stop(input logic [31:0] ctl, input lpmc_state_t m,
                        input int unsigned ev, input int b, input logic en);
    wr(`LPMC_OFF_IRQ_CLR, 32'h7);
    wr(`LPMC_OFF_IRQ_EN, 32'(en) << b);
    enter(ctl, m);
    `CHK({pwr.flash_on, pwr.sram_pwr_on, pwr.periph_run}, 3'b010)
    `CHK(pwr.wake_per_en, 1'b1)
    rd(`LPMC_OFF_STATUS, 32'hf, 32'(m));
    core_u.set_level(4, 4'h4);
    core_u.set_level(1, 4'h1);
    cyc(5);
    `CHK({ifo, gate}, 5'b10100)
    `CHK(pwr.ext_fast_osc_en, 1'b1)
    core_u.set_level(4, 4'h0);
    core_u.set_level(1, 4'h0);
    cyc(5);
    `CHK({ifo, gate}, 5'b00000)
    `CHK(pwr.ext_fast_osc_en, 1'b0)
    core_u.fire(ev);
    go(LPMC_RUN);
    `CHK(irq, en)
    rd(`LPMC_OFF_IRQ_STAT, 32'h1 << b, 32'h1 << b);
    wr(`LPMC_OFF_IRQ_EN, 32'h1 << b);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(`LPMC_OFF_IRQ_CLR, 32'h1 << b);
    cyc(2);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_flash();
    core_u.set_level(2, 4'h1);
    wr(`LPMC_OFF_CTRL, 32'h20);
    cyc(4);
    `CHK(pwr.flash_on, 1'b0)
    core_u.set_level(1, 4'h1);
    cyc(5);
    `CHK(pwr.flash_on, 1'b1)
    core_u.set_level(1, 4'h0);
    core_u.set_level(2, 4'h0);
    cyc(5);
    `CHK(pwr.flash_on, 1'b1)
    wr(`LPMC_OFF_CTRL, 32'h0);
  endtask

  task automatic t_standby(input logic ret);
    int n0;
    wr(`LPMC_OFF_PULL_UP, 32'h00ff);
    wr(`LPMC_OFF_PULL_DN, 32'hff00);
    enter(32'h3 | (32'(ret) << 4), LPMC_STANDBY);
    `CHK(pwr.sram_pwr_on, ret)
    n0 = n_rst;
    core_u.fire(1);
    cyc(6);
    `CHK(mode, LPMC_STANDBY)
    `CHK({pu, pd}, 32'h00ffff00)
    core_u.fire(ret ? 2 : 3);
    go(LPMC_RUN);
    cyc(1);
    `CHK(n_rst, n0 + 1)
    rd(`LPMC_OFF_CTRL, 32'hff, 32'h0);
  endtask

  task automatic t_shutdown();
    wr(`LPMC_OFF_PULL_UP, 32'h0f0f);
    wr(`LPMC_OFF_PULL_DN, 32'hf0f0);
    enter(32'h4, LPMC_SHUTDOWN);
    `CHK({pwr.main_regulator, pwr.low_power_regulator}, 2'b00)
    `CHK({pwr.flash_on, pwr.ext_fast_osc_en}, 2'b00)
    `CHK({pwr.wake_per_en, pwr.slow_osc_en}, 2'b01)
    `CHK({pu, pd}, 32'h0f0ff0f0)
    core_u.fire(1);
    cyc(6);
    `CHK(mode, LPMC_SHUTDOWN)
    core_u.fire(9);
    core_u.fire(10);
    cyc(6);
    `CHK(mode, LPMC_SHUTDOWN)
    core_u.fire(4);
    go(LPMC_RUN);
    enter(32'h4, LPMC_SHUTDOWN);
    `CHK({pu, pd}, 32'h0)
    core_u.fire(3);
    go(LPMC_RUN);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (12) @(posedge clk);
    `CHK(ana, 16'hffff)
    `CHK(rpu, 1'b1)
    rst_n <= 1'b1;
    t_reset();
    t_sleep();
    t_low_power_run();
    t_stop(32'h2, LPMC_STOP1, 5, 1, 1'b1);
    t_stop(32'h2, LPMC_STOP1, 6, 1, 1'b0);
    t_stop(32'h1, LPMC_STOP0, 7, 1, 1'b0);
    t_stop(32'h2, LPMC_STOP1, 8, 1, 1'b0);
    t_stop(32'h1, LPMC_STOP0, 11, 2, 1'b1);
    t_flash();
    t_standby(1'b0);
    t_standby(1'b1);
    t_shutdown();
    give_verdict();
  end

  // whole sequence needs well under 3000 cycles
  initial begin
    #100us;
    errors++;
    give_verdict();
  end
endmodule
